//--- pkg/ifmc_pkg.sv
/*
 * Package for the interrupt flag and mask control block: register addresses,
 * reset values, bit positions, source indices and edge-select codes.
 * Assumes an 8-bit memory-mapped register port driven by the CPU core.
 */
//
// Contract
// - Flag sets on request or write one.
// - Request flag registers reset to zero.
// - Watchdog flag usable only in interval mode.
// - Pin output-mode level changes still set flags.
// - Acknowledge clears the source flag.
// - Mask zero allows, mask one blocks.
// - Mask registers reset to all ones.
// - Watchdog mask reads undefined in reset mode.
// - Two-bit edge select per external pin.
// - Edge select register resets to zero.
// - Vectored acknowledge saves status, clears enable.
// - Global enable set by write, instructions, restore.
// - Status word resets to 02 hex.
// - Key select: bit0 group, bits 4-7 single.
// - Key select register resets to zero.
// - Falling edge on selected key sets flag.
// - Selected key pull-up only in input mode.
// - Fixed priority, watchdog highest, key lowest.
// - Acknowledge needs flag, unmasked, global enable.
// - Watchdog mode 1 overflow is non-maskable.

package ifmc_pkg;

    // ------------------------------------------------------------------
    // Register addresses.
    // ------------------------------------------------------------------
    localparam logic [15:0] ADDR_REQ_LO   = 16'hffe0;
    localparam logic [15:0] ADDR_REQ_HI   = 16'hffe1;
    localparam logic [15:0] ADDR_MASK_LO  = 16'hffe4;
    localparam logic [15:0] ADDR_MASK_HI  = 16'hffe5;
    localparam logic [15:0] ADDR_EDGE_SEL = 16'hffec;
    localparam logic [15:0] ADDR_KEY_SEL  = 16'hfff5;

    // ------------------------------------------------------------------
    // Reset values.
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_REQ   = 8'h00;
    localparam logic [7:0] RST_MASK  = 8'hff;
    localparam logic [7:0] RST_EDGE  = 8'h00;
    localparam logic [7:0] RST_KEY   = 8'h00;
    localparam logic [7:0] RST_PSW   = 8'h02;

    // ------------------------------------------------------------------
    // Bit positions.
    // ------------------------------------------------------------------
    localparam int PSW_IE_BIT    = 7;       // Global enable position in the status word.
    localparam int NUM_SRC       = 9;       // Maskable sources, priority order 0..8.
    localparam int KEY_GROUP_BIT = 0;       // Key pins 0..3 selected together.
    localparam int EDGE_LSB      = 2;       // Pin 0 edge field starts here.

    // Source indices, equal to priority.
    localparam int SRC_WDT = 0;
    localparam int SRC_P0  = 1;
    localparam int SRC_P1  = 2;
    localparam int SRC_P2  = 3;
    localparam int SRC_SRX = 4;
    localparam int SRC_STX = 5;
    localparam int SRC_T00 = 6;
    localparam int SRC_T20 = 7;
    localparam int SRC_KEY = 8;

    // Edge select codes.
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BAD  = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // Watchdog operating modes.
    typedef enum logic [1:0] {
        IFMC_WDT_INTERVAL,
        IFMC_WDT_RESET1,
        IFMC_WDT_RESET2
    } ifmc_wdt_mode_t;

endpackage : ifmc_pkg

//--- hw/ifmc_edge_det.sv
/*
 * Pin synchroniser and edge detector for one external input.
 * Assumes an asynchronous pin; three flops, change taken when 2nd and 3rd agree.
 */
`timescale 1ns/10ps
`default_nettype none

module ifmc_edge_det
    import ifmc_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk_sys,
    input  wire logic       reset,
    // Pin and selection.
    input  wire logic       pin_in,
    input  wire logic [1:0] edge_mode,
    // Detected event, one-cycle pulse.
    output logic            edge_hit
);

    logic       sync1_ff;   // First stage, read only by the second.
    logic       sync2_ff;   // Second stage.
    logic       sync3_ff;   // Third stage.
    logic       level_ff;   // Accepted level.
    logic       nxt_level;
    wire        agree;
    wire        rise;
    wire        fall;

    // ------------------------------------------------------------------
    // Synchroniser chain. Resets high, so an idle pulled-up pin gives no edge.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sync1_ff <= 1'b1;
            sync2_ff <= 1'b1;
            sync3_ff <= 1'b1;
            level_ff <= 1'b1;
        end else begin
            sync1_ff <= pin_in;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            level_ff <= nxt_level;
        end
    end

    // A change counts only when the last two stages agree.
    assign agree     = (sync2_ff == sync3_ff);
    assign nxt_level = agree ? sync3_ff : level_ff;
    assign rise      = agree && sync3_ff && !level_ff;
    assign fall      = agree && !sync3_ff && level_ff;

    // The prohibited code detects nothing.
    assign edge_hit = ((edge_mode == EDGE_FALL) && fall) ||
                      ((edge_mode == EDGE_RISE) && rise) ||
                      ((edge_mode == EDGE_BOTH) && (rise || fall));

endmodule : ifmc_edge_det

`default_nettype wire

//--- hw/ifmc_ctrl.sv
/*
 * Interrupt flag, mask, edge-select and key-return control with the global
 * enable held in the program status word.
 * Assumes the CPU core accesses registers with single-cycle byte read and write
 * strobes, and pulses acknowledge, instruction and restore strobes itself.
 */
`timescale 1ns/10ps
`default_nettype none

module ifmc_ctrl
    import ifmc_pkg::*;
(
    // Clock and reset.
    input  wire logic                 clk_sys,
    input  wire logic                 reset,
    // Register port from the core.
    input  wire logic [15:0]          reg_addr,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    input  wire logic [7:0]           reg_wdata,
    output logic [7:0]                reg_rdata,
    output logic                      reg_hit,
    // Status word access from the core.
    input  wire logic                 psw_wr,
    input  wire logic [7:0]           psw_wdata,
    input  wire logic                 enable_irq_instr,
    input  wire logic                 disable_irq_instr,
    input  wire logic                 return_from_irq,
    input  wire logic [7:0]           psw_restore,
    output logic [7:0]                psw_out,
    // Internal event sources, one-cycle pulses.
    input  wire logic                 watchdog_irq,
    input  wire ifmc_wdt_mode_t       wdt_mode,
    input  wire logic                 serial_rx_done_irq,
    input  wire logic                 three_wire_done_irq,
    input  wire logic                 serial_tx_done_irq,
    input  wire logic                 timer00_match_irq,
    input  wire logic                 timer20_match_irq,
    // External pins.
    input  wire logic [2:0]           ext_pin_in,
    input  wire logic [7:0]           key_pin_in,
    input  wire logic [7:0]           key_pin_out_mode,
    output logic [7:0]                key_pullup_en,
    // Request and acknowledge with the core.
    output logic                      irq_req,
    output logic [3:0]                irq_src,
    output logic                      nmi_req,
    input  wire logic                 irq_ack,
    input  wire logic                 nmi_ack
);

    // ------------------------------------------------------------------
    // State.
    // ------------------------------------------------------------------
    logic [NUM_SRC-1:0] flag_ff;        // Request flags, indexed by priority.
    logic [NUM_SRC-1:0] nxt_flag;
    logic [NUM_SRC-1:0] mask_ff;        // Mask flags, same index.
    logic [NUM_SRC-1:0] nxt_mask;
    logic [7:0]         edge_sel_ff;    // Edge select register.
    logic [7:0]         key_sel_ff;     // Key pin select register.
    logic [7:0]         psw_ff;         // Program status word.
    logic [7:0]         nxt_psw;
    logic               nmi_pend_ff;    // Pending non-maskable request.
    logic [7:0]         key_sync1_ff;   // Key synchroniser, first stage.
    logic [7:0]         key_sync2_ff;
    logic [7:0]         key_sync3_ff;
    logic [7:0]         key_lvl_ff;     // Accepted key levels.
    logic [7:0]         reg_rdata_ff;

    // ------------------------------------------------------------------
    // Address decode.
    // ------------------------------------------------------------------
    wire sel_req_lo  = (reg_addr == ADDR_REQ_LO);
    wire sel_req_hi  = (reg_addr == ADDR_REQ_HI);
    wire sel_mask_lo = (reg_addr == ADDR_MASK_LO);
    wire sel_mask_hi = (reg_addr == ADDR_MASK_HI);
    wire sel_edge    = (reg_addr == ADDR_EDGE_SEL);
    wire sel_key     = (reg_addr == ADDR_KEY_SEL);
    wire wdt_interval = (wdt_mode == IFMC_WDT_INTERVAL);
    wire wr_req_lo   = reg_wr && sel_req_lo;
    wire wr_req_hi   = reg_wr && sel_req_hi;
    wire wr_mask_lo  = reg_wr && sel_mask_lo;
    wire wr_mask_hi  = reg_wr && sel_mask_hi;

    assign reg_hit = sel_req_lo || sel_req_hi || sel_mask_lo ||
                     sel_mask_hi || sel_edge || sel_key;

    // ------------------------------------------------------------------
    // Register image from a byte write, indexed by source.
    // ------------------------------------------------------------------
    // Low byte carries sources 0..6 in bits 0..6; high byte has key at
    // bit 0 and timer 20 at bit 7.
    wire [NUM_SRC-1:0] wr_sel = {wr_req_hi, wr_req_hi, {7{wr_req_lo}}};
    wire [NUM_SRC-1:0] mk_sel = {wr_mask_hi, wr_mask_hi, {7{wr_mask_lo}}};
    wire [NUM_SRC-1:0] wr_val = {reg_wdata[0], reg_wdata[7], reg_wdata[6:0]};

    // ------------------------------------------------------------------
    // External pin edge detection.
    // ------------------------------------------------------------------
    // Pins in port output mode still feed the detector, so driving the pin
    // sets its flag; software masks first.
    wire [2:0] pin_hit;
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_pin
            ifmc_edge_det u_det (
                .clk_sys   (clk_sys),
                .reset     (reset),
                .pin_in    (ext_pin_in[gi]),
                .edge_mode (edge_sel_ff[EDGE_LSB+2*gi +: 2]),
                .edge_hit  (pin_hit[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Key return detection.
    // ------------------------------------------------------------------
    // Bit 0 enables key pins 0..3 as a group, bits 4..7 one pin each.
    wire [7:0] key_en = {key_sel_ff[7:4], {4{key_sel_ff[KEY_GROUP_BIT]}}};
    wire [7:0] key_agree = ~(key_sync2_ff ^ key_sync3_ff);
    wire [7:0] key_fall  = key_agree & ~key_sync3_ff & key_lvl_ff;
    wire [7:0] key_nxt_lvl = (key_agree & key_sync3_ff) | (~key_agree & key_lvl_ff);
    wire       key_hit   = |(key_fall & key_en);

    // Pull-up follows selection but never while the pin drives.
    assign key_pullup_en = key_en & ~key_pin_out_mode;

    // ------------------------------------------------------------------
    // Source events by priority index.
    // ------------------------------------------------------------------
    // The watchdog only raises a maskable flag in interval mode.
    wire wdt_mask_evt = watchdog_irq && wdt_interval;
    wire [NUM_SRC-1:0] src_evt = {key_hit, timer20_match_irq, timer00_match_irq,
                                  serial_tx_done_irq,
                                  serial_rx_done_irq || three_wire_done_irq,
                                  pin_hit, wdt_mask_evt};

    // ------------------------------------------------------------------
    // Priority selection.
    // ------------------------------------------------------------------
    wire [NUM_SRC-1:0] ready = flag_ff & ~mask_ff;
    logic [3:0] win_idx;
    logic       win_any;

    // Lowest index wins; scanning from the top lets lower indices override.
    always_comb begin
        win_idx = 4'h0;
        win_any = 1'b0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (ready[i]) begin
                win_idx = 4'(i);
                win_any = 1'b1;
            end
        end
    end

    // A maskable request is offered only with the global enable set.
    assign irq_req = win_any && psw_ff[PSW_IE_BIT];
    assign irq_src = win_idx;
    assign nmi_req = nmi_pend_ff;
    wire   take_irq = irq_req && irq_ack;

    // ------------------------------------------------------------------
    // Flag next state.
    // ------------------------------------------------------------------
    // Writes load the written bit and acknowledge clears; a hardware event in the same cycle wins.
    always_comb begin
        for (int i = 0; i < NUM_SRC; i++) begin
            nxt_flag[i] = flag_ff[i];
            if (wr_sel[i]) begin
                nxt_flag[i] = wr_val[i];
            end
            if (take_irq && (win_idx == 4'(i))) begin
                nxt_flag[i] = 1'b0;
            end
            if (src_evt[i]) begin
                nxt_flag[i] = 1'b1;
            end
        end
        // Outside interval mode the watchdog flag stays at zero.
        if (!wdt_interval) begin
            nxt_flag[SRC_WDT] = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Mask next state.
    // ------------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < NUM_SRC; i++) begin
            nxt_mask[i] = mk_sel[i] ? wr_val[i] : mask_ff[i];
        end
    end

    // ------------------------------------------------------------------
    // Status word next state.
    // ------------------------------------------------------------------
    // Restore overrides write and instructions; acknowledge has the last word and must leave IE clear.
    always_comb begin
        nxt_psw = psw_ff;
        if (psw_wr) begin
            nxt_psw = psw_wdata;
        end
        if (enable_irq_instr) begin
            nxt_psw[PSW_IE_BIT] = 1'b1;
        end
        if (disable_irq_instr) begin
            nxt_psw[PSW_IE_BIT] = 1'b0;
        end
        if (return_from_irq) begin
            nxt_psw = psw_restore;
        end
        if (take_irq || (nmi_ack && nmi_pend_ff)) begin
            nxt_psw[PSW_IE_BIT] = 1'b0;
        end
    end

    // The core stacks this word before the acknowledge clears IE.
    assign psw_out = psw_ff;

    // ------------------------------------------------------------------
    // Registers.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            flag_ff     <= '0;
            mask_ff     <= '1;
            edge_sel_ff <= RST_EDGE;
            key_sel_ff  <= RST_KEY;
            psw_ff      <= RST_PSW;
        end else begin
            flag_ff     <= nxt_flag;
            mask_ff     <= nxt_mask;
            psw_ff      <= nxt_psw;
            if (reg_wr && sel_edge) begin
                edge_sel_ff <= reg_wdata;
            end
            if (reg_wr && sel_key) begin
                key_sel_ff <= reg_wdata;
            end
        end
    end

    // Non-maskable watchdog request bypasses masks, enable and priority.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            nmi_pend_ff <= 1'b0;
        end else if (watchdog_irq && (wdt_mode == IFMC_WDT_RESET1)) begin
            nmi_pend_ff <= 1'b1;
        end else if (nmi_ack) begin
            nmi_pend_ff <= 1'b0;
        end
    end

    // Key synchroniser; idle pulled-up keys reset high.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            key_sync1_ff <= 8'hff;
            key_sync2_ff <= 8'hff;
            key_sync3_ff <= 8'hff;
            key_lvl_ff   <= 8'hff;
        end else begin
            key_sync1_ff <= key_pin_in;
            key_sync2_ff <= key_sync1_ff;
            key_sync3_ff <= key_sync2_ff;
            key_lvl_ff   <= key_nxt_lvl;
        end
    end

    // ------------------------------------------------------------------
    // Read data, registered one cycle after the read strobe.
    // ------------------------------------------------------------------
    // Reserved flag bits read zero, reserved mask bits read one. The watchdog
    // mask reads one in reset modes, an allowed value where it is undefined.
    wire [7:0] rd_req_lo  = {1'b0, flag_ff[6:0]};
    wire [7:0] rd_req_hi  = {flag_ff[SRC_T20], 6'h00, flag_ff[SRC_KEY]};
    wire [7:0] rd_mask_lo = {1'b1, mask_ff[6:1], mask_ff[SRC_WDT] | ~wdt_interval};
    wire [7:0] rd_mask_hi = {mask_ff[SRC_T20], 6'h3f, mask_ff[SRC_KEY]};
    wire [7:0] rd_mux = sel_req_lo  ? rd_req_lo  :
                        sel_req_hi  ? rd_req_hi  :
                        sel_mask_lo ? rd_mask_lo :
                        sel_mask_hi ? rd_mask_hi :
                        sel_edge    ? edge_sel_ff :
                        sel_key     ? key_sel_ff : 8'h00;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            reg_rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata_ff <= rd_mux;
        end
    end

    assign reg_rdata = reg_rdata_ff;

endmodule : ifmc_ctrl

`default_nettype wire

//--- dv/ifmc_ctrl_sva.sv
/* Port checker for ifmc_ctrl.
   Assumes one clock domain and the bind at the foot of this file. */
`timescale 1ns/10ps
`default_nettype none
module ifmc_ctrl_sva
    import ifmc_pkg::*;
(
    // Clock and reset.
    input wire logic       clk_sys,
    input wire logic       reset,
    // Core strobes and status.
    input wire logic       enable_irq_instr,
    input wire logic       disable_irq_instr,
    input wire logic       return_from_irq,
    input wire logic       irq_ack,
    input wire logic       nmi_ack,
    input wire logic [7:0] psw_out,
    input wire logic       irq_req,
    input wire logic       nmi_req,
    // Watchdog and key pins.
    input wire logic       watchdog_irq,
    input wire ifmc_wdt_mode_t wdt_mode,
    input wire logic [7:0] key_pin_out_mode,
    input wire logic [7:0] key_pullup_en
);
    // ------------------------------------------------------------
    // One domain, so clock and disable are stated once.
    // ------------------------------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // An accepted vectored request.
    sequence s_ack;
        irq_ack && irq_req;
    endsequence
    // A watchdog overflow in reset mode 1, not acked at once.
    sequence s_nmi;
        watchdog_irq && wdt_mode == IFMC_WDT_RESET1 && !nmi_ack;
    endsequence
    req_needs_ie_a: assert property (irq_req |-> psw_out[PSW_IE_BIT])
        else $error("request raised while disabled");
    ack_clr_ie_a: assert property (s_ack |=> !psw_out[PSW_IE_BIT] && !irq_req)
        else $error("acknowledge left enable set");
    ei_sets_a: assert property (enable_irq_instr && !disable_irq_instr && !return_from_irq
        && !irq_ack && !nmi_ack |=> psw_out[PSW_IE_BIT]) else $error("enable lost");
    di_clears_a: assert property (disable_irq_instr && !return_from_irq |=> !psw_out[PSW_IE_BIT])
        else $error("disable lost");
    nmi_set_a: assert property (s_nmi |=> nmi_req)
        else $error("watchdog overflow not taken");
    nmi_ack_a: assert property (nmi_ack && !watchdog_irq |=> !nmi_req && !psw_out[PSW_IE_BIT])
        else $error("nonmaskable ack incomplete");
    pullup_out_a: assert property ((key_pullup_en & key_pin_out_mode) == 8'h00)
        else $error("pull-up on output pin");
    reset_vals_a: assert property ($fell(reset) |-> psw_out == RST_PSW && !nmi_req && !irq_req)
        else $error("bad status after reset");
endmodule : ifmc_ctrl_sva
bind ifmc_ctrl ifmc_ctrl_sva u_sva (.clk_sys, .reset, .enable_irq_instr, .disable_irq_instr,
    .return_from_irq, .irq_ack, .nmi_ack, .psw_out, .irq_req, .nmi_req, .watchdog_irq,
    .wdt_mode, .key_pin_out_mode, .key_pullup_en);
`default_nettype wire

//--- dv/ifmc_core_model.sv
/* Core model that acknowledges a pending vectored request.
   Assumes the testbench enables it with ack_go. */
`timescale 1ns/10ps
`default_nettype none
module ifmc_core_model (
    // Clock and reset.
    input  wire logic clk_sys,
    input  wire logic reset,
    // Request, enable and acknowledge.
    input  wire logic irq_req,
    input  wire logic ack_go,
    output logic      irq_ack
);
    logic want_ff;  // Request seen, ack goes out at the next falling edge.
    // Sample on the rising edge; one ack per request, never two back to back.
    always @(posedge clk_sys or posedge reset) begin
        if (reset) want_ff <= 1'b0;
        else want_ff <= ack_go && irq_req && !irq_ack;
    end
    // Drive off the sampling edge so the design sees a settled strobe.
    always @(negedge clk_sys or posedge reset) begin
        if (reset) irq_ack <= 1'b0;
        else irq_ack <= want_ff;
    end
endmodule : ifmc_core_model
`default_nettype wire

//--- dv/tb_interrupt_flag_mask_control.sv
/* Testbench for ifmc_ctrl: register, event, pin and acknowledge tests.
   Assumes the core model and checker files are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module tb_interrupt_flag_mask_control;
    import ifmc_pkg::*;
    logic clk_sys, reset, reg_wr, reg_rd, reg_hit, psw_wr, enable_irq_instr, disable_irq_instr;
    logic return_from_irq, watchdog_irq, serial_rx_done_irq, three_wire_done_irq, serial_tx_done_irq;
    logic timer00_match_irq, timer20_match_irq, irq_req, nmi_req, irq_ack, nmi_ack, ack_go;
    logic [15:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, psw_wdata, psw_restore, psw_out, got;
    logic [7:0] key_pin_in, key_pin_out_mode, key_pullup_en;
    logic [2:0] ext_pin_in;
    logic [3:0] irq_src;
    ifmc_wdt_mode_t wdt_mode;
    int error_cnt, cmp_count, cyc;
    logic [15:0] adr [7] = '{ADDR_REQ_LO, ADDR_REQ_HI, ADDR_MASK_LO, ADDR_MASK_HI,
                             ADDR_EDGE_SEL, ADDR_KEY_SEL, 16'hffe2};
    logic [7:0]  rst [7] = '{RST_REQ, RST_REQ, RST_MASK, RST_MASK, RST_EDGE, RST_KEY, 8'h00};
    ifmc_ctrl DUT (.*);
    ifmc_core_model u_core (.clk_sys, .reset, .irq_req, .ack_go, .irq_ack);
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Compare one byte and count it.
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One write strobe; a gap cycle follows so strobes never merge.
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask : wr
    // Read data is registered, so it is taken one cycle after the strobe.
    task automatic rd(input logic [15:0] a);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        got = reg_rdata;
    endtask : rd
    task automatic pulse(ref logic s);
        @(negedge clk_sys);
        s = 1'b1;
        @(negedge clk_sys);
        s = 1'b0;
    endtask : pulse
    task automatic idle(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : idle
    task automatic close_out();
        $display("mismatches %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out
    // Cut a hang short well above the few hundred cycles the tests need.
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            close_out();
        end
    end
    initial begin
        {reset, reg_wr, reg_rd, psw_wr, enable_irq_instr, disable_irq_instr, return_from_irq} = 7'h7f & 7'h40;
        {watchdog_irq, serial_rx_done_irq, three_wire_done_irq, serial_tx_done_irq} = 4'h0;
        {timer00_match_irq, timer20_match_irq, nmi_ack, ack_go} = 4'h0;
        {reg_addr, reg_wdata, psw_wdata, psw_restore, key_pin_out_mode} = '0;
        {key_pin_in, ext_pin_in, wdt_mode, error_cnt, cmp_count, cyc} = {8'hff, 3'h7, IFMC_WDT_INTERVAL, 96'h0};
        idle(6);
        reset = 1'b0;
        foreach (adr[i]) begin
            rd(adr[i]);
            chk(got, rst[i]);
            chk({7'h0, reg_hit}, 8'(i < 6));
        end
        chk(psw_out, RST_PSW);
        // Every edge code on every pin; masks stay set from reset.
        for (int p = 0; p < 3; p++) for (int m = 0; m < 4; m++) begin
            wr(ADDR_EDGE_SEL, 8'(m << (EDGE_LSB + 2 * p)));
            wr(ADDR_REQ_LO, 8'h00);
            ext_pin_in[p] = 1'b0;
            idle(8);
            rd(ADDR_REQ_LO);
            chk(got, (m[0] == m[1]) ? 8'(2 << p) : 8'h00);
            wr(ADDR_REQ_LO, 8'h00);
            ext_pin_in[p] = 1'b1;
            idle(8);
            rd(ADDR_REQ_LO);
            chk(got, m[0] ? 8'(2 << p) : 8'h00);
        end
        // Status word by write, disable instruction and restore.
        psw_wdata = 8'h80;
        pulse(psw_wr);
        chk(psw_out, 8'h80);
        pulse(disable_irq_instr);
        chk(psw_out, 8'h00);
        psw_restore = 8'h82;
        pulse(return_from_irq);
        chk(psw_out, 8'h82);
        pulse(disable_irq_instr);
        // All nine flags by software, served one by one in priority order.
        wr(ADDR_MASK_LO, 8'h80);
        wr(ADDR_MASK_HI, 8'h7e);
        wr(ADDR_REQ_LO, 8'h7f);
        wr(ADDR_REQ_HI, 8'h81);
        chk({7'h0, irq_req}, 8'h00);
        ack_go = 1'b1;
        for (int i = 0; i < NUM_SRC; i++) begin
            pulse(enable_irq_instr);
            chk({4'h0, irq_src}, 8'(i));
            idle(3);
            chk(psw_out, 8'h02);
        end
        ack_go = 1'b0;
        rd(ADDR_REQ_LO);
        chk(got, 8'h00);
        rd(ADDR_REQ_HI);
        chk(got, 8'h00);
        // Peripheral events set their flags.
        @(negedge clk_sys);
        {serial_rx_done_irq, serial_tx_done_irq, timer00_match_irq, timer20_match_irq} = 4'hf;
        @(negedge clk_sys);
        {serial_rx_done_irq, serial_tx_done_irq, timer00_match_irq, timer20_match_irq} = 4'h0;
        pulse(three_wire_done_irq);
        rd(ADDR_REQ_LO);
        chk(got, 8'h70);
        rd(ADDR_REQ_HI);
        chk(got, 8'h80);
        // Watchdog in reset mode: flag held at zero, mode 1 overflow is nonmaskable, mode 2 raises none.
        wdt_mode = IFMC_WDT_RESET1;
        wr(ADDR_REQ_LO, 8'h01);
        rd(ADDR_REQ_LO);
        chk(got, 8'h00);
        rd(ADDR_MASK_LO);
        chk(got, 8'h81);
        pulse(watchdog_irq);
        chk({7'h0, nmi_req}, 8'h01);
        pulse(nmi_ack);
        chk({7'h0, nmi_req}, 8'h00);
        wdt_mode = IFMC_WDT_RESET2;
        pulse(watchdog_irq);
        chk({7'h0, nmi_req}, 8'h00);
        // Key pins: mask, select, clear, then single pin and group.
        wr(ADDR_MASK_HI, 8'hff);
        wr(ADDR_KEY_SEL, 8'h10);
        wr(ADDR_REQ_HI, 8'h00);
        chk(key_pullup_en, 8'h10);
        key_pin_out_mode = 8'h10;
        idle(1);
        chk(key_pullup_en, 8'h00);
        key_pin_out_mode = 8'h00;
        key_pin_in = 8'hdf;
        idle(8);
        rd(ADDR_REQ_HI);
        chk(got, 8'h00);
        key_pin_in = 8'hcf;
        idle(8);
        rd(ADDR_REQ_HI);
        chk(got, 8'h01);
        wr(ADDR_KEY_SEL, 8'h01);
        wr(ADDR_REQ_HI, 8'h00);
        chk(key_pullup_en, 8'h0f);
        key_pin_in = 8'hcb;
        idle(8);
        rd(ADDR_REQ_HI);
        chk(got, 8'h01);
        close_out();
    end
endmodule : tb_interrupt_flag_mask_control
`default_nettype wire
